// ---- core/sbp_map.svh ----
// Register offsets, field positions and reset values of the six-pin port
`ifndef SBP_MAP_SVH
`define SBP_MAP_SVH
`define SBP_ADDR_FUNC_SEL   10'h024
`define SBP_ADDR_DIR_LOW    10'h02C
`define SBP_ADDR_DIR_HIGH   10'h02D
`define SBP_FSEL_STOP_MODE_CLEAR_INPUT_BIT  3
`define SBP_FSEL_INT_BIT    0
`define SBP_DIR_RST         4'h0
`define SBP_FSEL_RST        2'h0
`define SBP_LATCH_RST       6'h3F
`define SBP_PIN_STOP_MODE_CLEAR_INPUT       4
`define SBP_PIN_INT         0
`endif

// ---- core/sbp_pkg.sv ----
// Types shared by the six-pin port
package sbp_pkg;
  typedef enum logic [3:0] {
    SBP_OP_NONE  = 4'b0001,
    SBP_OP_SET   = 4'b0010,
    SBP_OP_CLEAR = 4'b0100,
    SBP_OP_TEST  = 4'b1000
  } sbp_op_t;

  typedef struct packed {
    sbp_op_t    op;
    logic [2:0] pin;
  } sbp_pin_cmd_t;

  typedef struct packed {
    logic       wrEn;
    logic [9:0] addr;
    logic [3:0] data;
  } sbp_mem_wr_t;
endpackage : sbp_pkg

// ---- core/sbp_pin_cell.sv ----
// One port pin: output latch, buffer enable and pull-up
`timescale 1ns/10ps
`include "sbp_map.svh"
module sbp_pin_cell (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic setLatch,
  input  wire logic clrLatch,
  input  wire logic stopMode,
  input  wire logic dirBit,
  input  wire logic sharedSel,
  input  wire logic pullupGlobalEnable,
  output logic      latchQ,
  output logic      padOut,
  output logic      padOe,
  output logic      padPullup
);
  logic latch_r;
  logic latch_nxt;

  // Set and clear come only from the bit instructions [RULE_02] [RULE_03]
  assign latch_nxt = (!nrst || stopMode) ? 1'b1 :           // [RULE_07]
                     setLatch            ? 1'b1 :           // [RULE_02]
                     clrLatch            ? 1'b0 : latch_r;  // [RULE_03]

  always_ff @(posedge ref_clk) begin
    latch_r <= latch_nxt;
  end

  assign latchQ    = latch_r;
  assign padOut    = latch_r;
  // Shared function or stop mode leaves the buffer off [RULE_06] [RULE_16]
  assign padOe     = dirBit && !sharedSel && !stopMode;       // [RULE_13]
  assign padPullup = pullupGlobalEnable && latch_r;           // [RULE_14]
endmodule : sbp_pin_cell

// ---- core/sbp_six_pin_bit_port.sv ----
// Six-pin bit-addressable port with shared stop-clear and interrupt pins
//
// Contract
// [RULE_01] Six pins, each accessed as one bit
// [RULE_02] Set instruction loads pin latch with one
// [RULE_03] Clear instruction loads pin latch with zero
// [RULE_04] Latches reachable only through bit instructions
// [RULE_05] Test instruction returns one pin level
// [RULE_06] Direction zero floats pin, one drives latch
// [RULE_07] Latches forced to one on reset, stop
// [RULE_08] Low direction maps pins 3-0, high 5-4
// [RULE_09] Direction registers write-only in data memory
// [RULE_10] Function select write-only, two bits, reset zero
// [RULE_11] Select bit 3 makes pin 4 stop-clear input
// [RULE_12] Select bit 0 makes pin 0 interrupt input
// [RULE_13] Pins 1,2,3,5 follow direction bit only
// [RULE_14] Pull-up on when enabled and latch one
// [RULE_15] Standby holds pins at prior values
// [RULE_16] Stop clears selections, floats all pins
`timescale 1ns/10ps
`include "sbp_map.svh"
module sbp_six_pin_bit_port #(
  parameter int PIN_COUNT = 6
) (
  input  wire logic                   ref_clk,
  input  wire logic                   nrst,
  input  wire sbp_pkg::sbp_pin_cmd_t  pinCmd,
  input  wire sbp_pkg::sbp_mem_wr_t   memWr,
  input  wire logic                   stopMode,
  input  wire logic                   standbyMode,
  input  wire logic                   pullupGlobalEnable,
  input  wire logic [PIN_COUNT-1:0]   padIn,
  output logic [PIN_COUNT-1:0]        padOut,
  output logic [PIN_COUNT-1:0]        padOe,
  output logic [PIN_COUNT-1:0]        padPullup,
  output logic                        testResult,
  output logic                        stopModeClearInput,
  output logic                        externalInterruptZero,
  output logic                        eventCounterInput
);
  logic [3:0]           lowDir_r;
  logic [1:0]           highDir_r;
  logic [1:0]           funcSel_r;
  logic                 testResult_r;
  logic [PIN_COUNT-1:0] dirBits;
  logic [PIN_COUNT-1:0] sharedSel;
  logic [PIN_COUNT-1:0] pinSel;
  logic [PIN_COUNT-1:0] setVec;
  logic [PIN_COUNT-1:0] clrVec;
  logic                 opSet;
  logic                 opClear;
  logic                 opTest;
  logic                 cpuRun;
  logic                 wrLow;
  logic                 wrHigh;
  logic                 wrSel;
  logic                 stopClearSel;
  logic                 intSel;

  function automatic logic [PIN_COUNT-1:0] pin_decode(input logic [2:0] idx);
    pin_decode = '0;
    if (idx < 3'(PIN_COUNT)) begin
      pin_decode[idx] = 1'b1;
    end
  endfunction : pin_decode

  // Shared by every register strobe of the data memory window
  function automatic logic reg_hit(input sbp_pkg::sbp_mem_wr_t wr,
                                   input logic [9:0]           offset);
    reg_hit = wr.wrEn && (wr.addr == offset);
  endfunction : reg_hit

  // Register writes and instructions are only taken while the CPU runs
  assign cpuRun = !standbyMode && !stopMode;                  // [RULE_15]
  assign wrLow  = cpuRun && reg_hit(memWr, `SBP_ADDR_DIR_LOW);  // [RULE_09]
  assign wrHigh = cpuRun && reg_hit(memWr, `SBP_ADDR_DIR_HIGH); // [RULE_09]
  assign wrSel  = cpuRun && reg_hit(memWr, `SBP_ADDR_FUNC_SEL); // [RULE_10]
  assign pinSel = cpuRun ? pin_decode(pinCmd.pin) : '0;       // [RULE_01]

  assign opSet   = pinCmd.op == sbp_pkg::SBP_OP_SET;
  assign opClear = pinCmd.op == sbp_pkg::SBP_OP_CLEAR;
  assign opTest  = pinCmd.op == sbp_pkg::SBP_OP_TEST;
  assign setVec  = pinSel & {PIN_COUNT{opSet}};               // [RULE_02]
  assign clrVec  = pinSel & {PIN_COUNT{opClear}};             // [RULE_03]

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      lowDir_r  <= `SBP_DIR_RST;                              // [RULE_08]
      highDir_r <= 2'(`SBP_DIR_RST);                          // [RULE_08]
    end else begin
      if (wrLow)  lowDir_r  <= memWr.data;                    // [RULE_08]
      if (wrHigh) highDir_r <= memWr.data[1:0];               // [RULE_08]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst || stopMode) begin
      funcSel_r <= `SBP_FSEL_RST;                             // [RULE_16]
    end else if (wrSel) begin
      funcSel_r <= {memWr.data[`SBP_FSEL_STOP_MODE_CLEAR_INPUT_BIT],
                    memWr.data[`SBP_FSEL_INT_BIT]};           // [RULE_10]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      testResult_r <= 1'b0;
    end else if (opTest && |pinSel) begin
      testResult_r <= |(padIn & pinSel);                      // [RULE_05]
    end
  end

  assign stopClearSel = funcSel_r[1];
  assign intSel       = funcSel_r[0];
  assign dirBits      = {highDir_r, lowDir_r};                // [RULE_08]

  always_comb begin
    sharedSel = '0;
    sharedSel[`SBP_PIN_STOP_MODE_CLEAR_INPUT] = stopClearSel;                 // [RULE_11]
    sharedSel[`SBP_PIN_INT]   = intSel;                       // [RULE_12]
  end

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g = g + 1) begin : gPin
      sbp_pin_cell uCell (
        .ref_clk            (ref_clk),
        .nrst               (nrst),
        .setLatch           (setVec[g]),                      // [RULE_04]
        .clrLatch           (clrVec[g]),                      // [RULE_04]
        .stopMode           (stopMode),
        .dirBit             (dirBits[g]),
        .sharedSel          (sharedSel[g]),
        .pullupGlobalEnable (pullupGlobalEnable),
        .latchQ             (),
        .padOut             (padOut[g]),
        .padOe              (padOe[g]),
        .padPullup          (padPullup[g])
      );
    end
  endgenerate

  assign testResult = testResult_r;
  // Shared inputs read the pad only while selected; idle level is high
  assign stopModeClearInput    = stopClearSel ? padIn[`SBP_PIN_STOP_MODE_CLEAR_INPUT] : 1'b1;
  assign externalInterruptZero = intSel ? padIn[`SBP_PIN_INT] : 1'b1;
  assign eventCounterInput     = intSel ? padIn[`SBP_PIN_INT] : 1'b1;
endmodule : sbp_six_pin_bit_port

// ---- testbench/sbp_port_assertions.sv ----
// Concurrent checks on the six-pin port outputs
`timescale 1ns/10ps
module sbp_port_checker #(
  parameter int PIN_COUNT = 6
) (
  input wire logic                  ref_clk,
  input wire logic                  nrst,
  input wire sbp_pkg::sbp_pin_cmd_t pinCmd,
  input wire logic                  stopMode,
  input wire logic                  standbyMode,
  input wire logic                  pullupGlobalEnable,
  input wire logic [PIN_COUNT-1:0]  padIn,
  input wire logic [PIN_COUNT-1:0]  padOut,
  input wire logic [PIN_COUNT-1:0]  padOe,
  input wire logic [PIN_COUNT-1:0]  padPullup,
  input wire logic                  testResult,
  input wire logic                  stopModeClearInput,
  input wire logic                  externalInterruptZero
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence sTake(o);
    pinCmd.op == o && pinCmd.pin < 6 && !stopMode && !standbyMode;
  endsequence
  sequence sHold;
    standbyMode && !stopMode ##1 !stopMode;
  endsequence
  AST_SET: assert property (sTake(sbp_pkg::SBP_OP_SET)
    |=> padOut[$past(pinCmd.pin)])
    else $error("set did not load one");
  AST_CLR: assert property (sTake(sbp_pkg::SBP_OP_CLEAR)
    |=> !padOut[$past(pinCmd.pin)])
    else $error("clear did not load zero");
  AST_TEST: assert property (sTake(sbp_pkg::SBP_OP_TEST)
    |=> testResult == $past(padIn[pinCmd.pin]))
    else $error("test result wrong");
  AST_STOP: assert property (stopMode
    |-> padOe == 6'h00 ##1 padOut == 6'h3F)
    else $error("stop did not float and set");
  AST_PULL: assert property (padPullup
    == (padOut & {PIN_COUNT{pullupGlobalEnable}}))
    else $error("pull-up wrong");
  AST_STBY: assert property (sHold
    |-> $stable(padOut) && $stable(padOe))
    else $error("pins moved in standby");
  AST_INT: assert property (padOe[0] |-> externalInterruptZero)
    else $error("interrupt input not idle");
  AST_STOP_MODE_CLEAR_INPUT: assert property (padOe[4] |-> stopModeClearInput)
    else $error("stop clear input not idle");
endmodule : sbp_port_checker
bind sbp_six_pin_bit_port sbp_port_checker #(.PIN_COUNT(PIN_COUNT)) i_chk (
  .ref_clk, .nrst, .pinCmd, .stopMode, .standbyMode, .pullupGlobalEnable,
  .padIn, .padOut, .padOe, .padPullup, .testResult, .stopModeClearInput,
  .externalInterruptZero);

// ---- testbench/sbp_board_model.sv ----
// Board side of the six pins
`timescale 1ns/10ps
module sbp_board_model (
  input  wire logic [5:0] padOut,
  input  wire logic [5:0] padOe,
  input  wire logic [5:0] boardLevel,
  output logic      [5:0] padIn
);
  // Floating pins show the board pattern
  assign padIn = (padOe & padOut) | (~padOe & boardLevel);
endmodule : sbp_board_model

// ---- testbench/sbp_six_pin_bit_port_tb_top.sv ----
// Randomised self-checking bench of the six-pin port
`timescale 1ns/10ps
module sbp_six_pin_bit_port_tb_top;
  logic ref_clk = 0, nrst = 0, stopMode = 0, standbyMode = 0, pu = 0;
  sbp_pkg::sbp_pin_cmd_t pinCmd = '{sbp_pkg::SBP_OP_NONE, 3'h0};
  sbp_pkg::sbp_mem_wr_t  memWr = '0;
  logic [5:0]  padIn, padOut, padOe, padPullup, ext = 0, lat, dir, oe, lvl;
  logic        testResult, stop_mode_clear_input, intZ, evn, tr, s0, s4;
  logic [20:0] got, exp;
  logic [31:0] seed = 32'h0000_6D88;
  logic [9:0]  adr [4] = '{10'h024, 10'h02C, 10'h02D, 10'h02E};
  int          fail_count = 0, checks = 0, k;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  task automatic results;
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  sbp_six_pin_bit_port i_sbp_six_pin_bit_port (.ref_clk, .nrst, .pinCmd,
    .memWr, .stopMode, .standbyMode, .pullupGlobalEnable(pu), .padIn,
    .padOut, .padOe, .padPullup, .testResult, .stopModeClearInput(stop_mode_clear_input),
    .externalInterruptZero(intZ), .eventCounterInput(evn));
  sbp_board_model i_sbp_board_model (.padOut, .padOe, .boardLevel(ext),
    .padIn);
  assign oe = dir & ~{1'b0, s4, 3'b000, s0}
              & {6{~stopMode}};
  assign lvl = (oe & lat) | (~oe & ext);
  assign got = {padOut, padOe, padPullup, testResult, stop_mode_clear_input, intZ, evn};
  assign exp = {lat, oe, lat & {6{pu}}, tr, s4 ? ext[4] : 1'b1,
                s0 ? ext[0] : 1'b1, s0 ? ext[0] : 1'b1};
  initial forever #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (!nrst) begin
      {lat, dir, s0, s4, tr} = {6'h3F, 6'h00, 3'b000};
    end else if (stopMode) begin
      {lat, s0, s4} = {6'h3F, 2'b00};
    end else if (!standbyMode) begin
      if (pinCmd.pin < 6) begin
        case (pinCmd.op)
          sbp_pkg::SBP_OP_SET:   lat[pinCmd.pin] = 1'b1;
          sbp_pkg::SBP_OP_CLEAR: lat[pinCmd.pin] = 1'b0;
          sbp_pkg::SBP_OP_TEST:  tr = lvl[pinCmd.pin];
          default: ;
        endcase
      end
      if (memWr.wrEn) begin
        case (memWr.addr)
          10'h024: {s4, s0} = {memWr.data[3], memWr.data[0]};
          10'h02C: dir[3:0] = memWr.data;
          10'h02D: dir[5:4] = memWr.data[1:0];
          default: ;
        endcase
      end
    end
  end
  initial begin
    repeat (5) @(negedge ref_clk);
    for (k = 0; k < 3000; k++) begin
      @(negedge ref_clk);
      checks++;
      if (got !== exp) begin
        fail_count++;
        $display("ERROR %0t port state differs from model", $time);
      end
      seed = xs(seed);
      nrst <= k != 1500;
      stopMode <= seed[7:4] == 4'h0;
      standbyMode <= seed[11:8] == 4'h0;
      pu <= seed[12];
      ext <= seed[18:13];
      pinCmd <= '{sbp_pkg::sbp_op_t'(4'h1 << seed[20:19]), seed[23:21]};
      memWr <= '{seed[24], adr[seed[26:25]], seed[30:27]};
    end
    results();
  end
endmodule : sbp_six_pin_bit_port_tb_top
